// ### sdcf_pkg.sv
// Shared constants, types and helpers of the single-clock FIFO controller
package sdcf_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int PTR_W     = 13;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 18;
  localparam int ROW_W     = 9;
  localparam int ROWS      = 512;
  localparam int ROW_SEL_W = 9;
  localparam int BIT_SEL_W = 3;

  localparam logic [PTR_W-1:0] CAPACITY_BITS = 13'h1000;
  localparam logic [PTR_W-1:0] PTR_RST       = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RST     = 18'h00000;

  // ****************************************************************
  // Aspect-ratio codes
  // ****************************************************************
  localparam logic [2:0] WIDTH_X1  = 3'h0;
  localparam logic [2:0] WIDTH_X2  = 3'h1;
  localparam logic [2:0] WIDTH_X4  = 3'h2;
  localparam logic [2:0] WIDTH_X9  = 3'h3;
  localparam logic [2:0] WIDTH_X18 = 3'h4;

  // Pointer steps in bit-address units; nine-bit words use eight units
  localparam logic [PTR_W-1:0] STEP_X1   = 13'h0001;
  localparam logic [PTR_W-1:0] STEP_X2   = 13'h0002;
  localparam logic [PTR_W-1:0] STEP_X4   = 13'h0004;
  localparam logic [PTR_W-1:0] STEP_X9   = 13'h0008;
  localparam logic [PTR_W-1:0] STEP_X18  = 13'h0010;
  localparam logic [PTR_W-1:0] STEP_NONE = 13'h0000;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [PTR_W-1:0]  wptr;
    logic [PTR_W-1:0]  rptr;
    logic [PTR_W-1:0]  wgray_s1;
    logic [PTR_W-1:0]  wgray_s2;
    logic [PTR_W-1:0]  rgray_s1;
    logic [PTR_W-1:0]  rgray_s2;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] read_pipeline_select;
  } sdcf_state_t;

  localparam sdcf_state_t STATE_RST = '{
    wptr:     PTR_RST,
    rptr:     PTR_RST,
    wgray_s1: PTR_RST,
    wgray_s2: PTR_RST,
    rgray_s1: PTR_RST,
    rgray_s2: PTR_RST,
    rdata:    DATA_RST,
    read_pipeline_select:    DATA_RST
  };

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [PTR_W-1:0] width_step(input logic [2:0] code);
    logic [PTR_W-1:0] s;
    s = STEP_NONE;
    unique case (code)
      WIDTH_X1:  s = STEP_X1;
      WIDTH_X2:  s = STEP_X2;
      WIDTH_X4:  s = STEP_X4;
      WIDTH_X9:  s = STEP_X9;
      WIDTH_X18: s = STEP_X18;
      default:   s = STEP_NONE;
    endcase
    return s;
  endfunction

  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// ### sdcf_fifo.sv
// Dual-port FIFO controller with one embedded RAM block and status flags
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps

module sdcf_fifo #(
  parameter bit WRITE_STROBE_ACTIVE_HIGH = 1'b0,
  parameter bit READ_STROBE_ACTIVE_HIGH  = 1'b1
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_reset_n,
  input  wire logic [2:0]                    i_write_width_code,
  input  wire logic [2:0]                    i_read_width_code,
  input  wire logic                          i_write_port_select_n,
  input  wire logic                          i_read_port_select_n,
  input  wire logic                          i_write_strobe,
  input  wire logic                          i_read_strobe,
  input  wire logic                          i_read_pipeline_select,
  input  wire logic [sdcf_pkg::DATA_W-1:0]   i_write_data_bus,
  input  wire logic                          i_empty_stop,
  input  wire logic                          i_full_stop,
  input  wire logic [sdcf_pkg::ADDR_W-1:0]   i_almost_full_threshold,
  input  wire logic [sdcf_pkg::ADDR_W-1:0]   i_almost_empty_threshold,
  output logic      [sdcf_pkg::DATA_W-1:0]   o_read_data,
  output logic                               o_full,
  output logic                               o_empty,
  output logic                               o_almost_full,
  output logic                               o_almost_empty
);

  // ****************************************************************
  // Storage and state
  // ****************************************************************
  logic [sdcf_pkg::ROW_W-1:0] mem [sdcf_pkg::ROWS];

  sdcf_pkg::sdcf_state_t state_r;
  sdcf_pkg::sdcf_state_t state_nxt;

  logic                             rst_all;
  logic [sdcf_pkg::PTR_W-1:0]       wstep;
  logic [sdcf_pkg::PTR_W-1:0]       rstep;
  logic [sdcf_pkg::PTR_W-1:0]       rptr_seen;
  logic [sdcf_pkg::PTR_W-1:0]       wptr_seen;
  logic [sdcf_pkg::PTR_W-1:0]       wfill;
  logic [sdcf_pkg::PTR_W-1:0]       rfill;
  logic [sdcf_pkg::PTR_W-1:0]       wroom;
  logic                             full;
  logic                             empty;
  logic                             wr_req;
  logic                             rd_req;
  logic                             wr_en;
  logic                             rd_en;
  logic [sdcf_pkg::ROW_SEL_W-1:0]   wrow;
  logic [sdcf_pkg::BIT_SEL_W-1:0]   wbit;
  logic [sdcf_pkg::ROW_SEL_W-1:0]   rrow;
  logic [sdcf_pkg::BIT_SEL_W-1:0]   rbit;
  logic [sdcf_pkg::DATA_W-1:0]      rword;

  // ****************************************************************
  // Flags
  // ****************************************************************
  assign rst_all = i_rst | ~i_reset_n;

  // Reserved codes yield a zero step, which disables that port
  assign wstep = sdcf_pkg::width_step(i_write_width_code);
  assign rstep = sdcf_pkg::width_step(i_read_width_code);

  // Each side only sees the other's pointer after two stages
  assign rptr_seen = sdcf_pkg::gray2bin(state_r.rgray_s2);
  assign wptr_seen = sdcf_pkg::gray2bin(state_r.wgray_s2);

  assign wfill = state_r.wptr - rptr_seen;
  assign rfill = wptr_seen - state_r.rptr;
  assign wroom = sdcf_pkg::CAPACITY_BITS - wfill;

  assign full  = (wstep == sdcf_pkg::STEP_NONE) | (wroom < wstep);
  assign empty = (rstep == sdcf_pkg::STEP_NONE) | (rfill < rstep);

  assign o_full         = full;
  assign o_empty        = empty;
  assign o_almost_full  = wfill >= {1'b0, i_almost_full_threshold};
  assign o_almost_empty = rfill <= {1'b0, i_almost_empty_threshold};

  // ****************************************************************
  // Access qualification
  // ****************************************************************
  assign wr_req = ~i_write_port_select_n & (i_write_strobe == WRITE_STROBE_ACTIVE_HIGH);
  assign rd_req = ~i_read_port_select_n & (i_read_strobe == READ_STROBE_ACTIVE_HIGH);

  // Stop inputs decide whether a flagged state halts the counter
  assign wr_en = ~rst_all & wr_req & (wstep != sdcf_pkg::STEP_NONE)
               & (~full | ~i_full_stop);
  assign rd_en = ~rst_all & rd_req & (rstep != sdcf_pkg::STEP_NONE)
               & (~empty | ~i_empty_stop);

  assign wrow = state_r.wptr[sdcf_pkg::ADDR_W-1:sdcf_pkg::BIT_SEL_W];
  assign wbit = state_r.wptr[sdcf_pkg::BIT_SEL_W-1:0];
  assign rrow = state_r.rptr[sdcf_pkg::ADDR_W-1:sdcf_pkg::BIT_SEL_W];
  assign rbit = state_r.rptr[sdcf_pkg::BIT_SEL_W-1:0];

  // ****************************************************************
  // Read word assembly
  // ****************************************************************
  always_comb begin
    rword = sdcf_pkg::DATA_RST;
    unique case (i_read_width_code)
      sdcf_pkg::WIDTH_X9: begin
        rword[sdcf_pkg::ROW_W-1:0] = mem[rrow];
      end
      sdcf_pkg::WIDTH_X18: begin
        rword = {mem[rrow + 9'h001], mem[rrow]};
      end
      default: begin
        for (int k = 0; k < 4; k++) begin
          if (k < int'(rstep)) begin
            rword[k] = mem[rrow][rbit + 3'(k)];
          end
        end
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    // Address bits wrap at the mode's last index as the step divides 4096; the 13-bit counters wrap at 8192
    if (wr_en) begin
      state_nxt.wptr = state_r.wptr + wstep;
    end
    if (rd_en) begin
      state_nxt.rptr = state_r.rptr + rstep;
      state_nxt.rdata = rword;
    end
    // Second output stage keeps still while the read port is deselected
    if (~i_read_port_select_n) begin
      state_nxt.read_pipeline_select = state_r.rdata;
    end
    state_nxt.wgray_s1 = sdcf_pkg::bin2gray(state_r.wptr);
    state_nxt.wgray_s2 = state_r.wgray_s1;
    state_nxt.rgray_s1 = sdcf_pkg::bin2gray(state_r.rptr);
    state_nxt.rgray_s2 = state_r.rgray_s1;
    if (rst_all) begin
      state_nxt = sdcf_pkg::STATE_RST;
    end
  end

  always_ff @(posedge i_clk) begin
    state_r <= state_nxt;
  end

  // ****************************************************************
  // Memory write, never reset
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      unique case (i_write_width_code)
        sdcf_pkg::WIDTH_X9: begin
          mem[wrow] <= i_write_data_bus[sdcf_pkg::ROW_W-1:0];
        end
        sdcf_pkg::WIDTH_X18: begin
          mem[wrow]          <= i_write_data_bus[sdcf_pkg::ROW_W-1:0];
          mem[wrow + 9'h001] <= i_write_data_bus[sdcf_pkg::DATA_W-1:sdcf_pkg::ROW_W];
        end
        default: begin
          for (int k = 0; k < 4; k++) begin
            if (k < int'(wstep)) begin
              mem[wrow][wbit + 3'(k)] <= i_write_data_bus[k];
            end
          end
        end
      endcase
    end
  end

  assign o_read_data = i_read_pipeline_select ? state_r.read_pipeline_select : state_r.rdata;

endmodule

// ### sdcf_fifo_properties.sv
// Port assertions for the FIFO controller
`timescale 1ns/100ps
module sdcf_fifo_chk #(
  parameter bit WRITE_STROBE_ACTIVE_HIGH = 1'b0,
  parameter bit READ_STROBE_ACTIVE_HIGH  = 1'b1
) (
  input wire logic                        i_clk,
  input wire logic                        i_rst,
  input wire logic                        i_reset_n,
  input wire logic [2:0]                  i_write_width_code,
  input wire logic [2:0]                  i_read_width_code,
  input wire logic                        i_write_port_select_n,
  input wire logic                        i_read_port_select_n,
  input wire logic                        i_write_strobe,
  input wire logic                        i_read_strobe,
  input wire logic                        i_read_pipeline_select,
  input wire logic                        i_empty_stop,
  input wire logic                        i_full_stop,
  input wire logic [sdcf_pkg::DATA_W-1:0] o_read_data,
  input wire logic                        o_full,
  input wire logic                        o_empty,
  input wire logic                        o_almost_full,
  input wire logic                        o_almost_empty
);
  logic rs, rq, wa, ra, eq;
  assign rs = i_rst || !i_reset_n;
  assign rq = !i_read_port_select_n && (i_read_strobe == READ_STROBE_ACTIVE_HIGH);
  assign wa = !i_write_port_select_n && (i_write_strobe == WRITE_STROBE_ACTIVE_HIGH) && !rs
              && i_write_width_code < 3'h5 && !(o_full && i_full_stop);
  assign ra = rq && !rs && i_read_width_code < 3'h5 && !(o_empty && i_empty_stop);
  assign eq = i_write_width_code == i_read_width_code && i_read_width_code < 3'h5;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (rs);

  property p_rst;
    $fell(rs) |-> o_empty && o_almost_empty && o_read_data == '0;
  endproperty
  property p_hold;
    i_read_port_select_n ##1 $stable(i_read_pipeline_select) |-> $stable(o_read_data);
  endproperty
  property p_empty_stop;
    o_empty && i_empty_stop && rq && !i_read_pipeline_select ##1 !i_read_pipeline_select
      |-> $stable(o_read_data);
  endproperty
  property p_empty;
    o_empty && wa && eq && i_empty_stop && !$past(wa) && !$past(wa, 2)
      |=> o_empty ##1 o_empty ##1 !o_empty;
  endproperty
  property p_full;
    o_full && ra && eq && i_full_stop && !$past(ra) && !$past(ra, 2)
      |=> o_full ##1 o_full ##1 !o_full;
  endproperty
  property p_almost_full_flag;
    o_full && eq |-> o_almost_full;
  endproperty
  property p_almost_empty_flag;
    o_empty && eq |-> o_almost_empty;
  endproperty
  property p_rsv;
    (i_write_width_code < 3'h5 || o_full) && (i_read_width_code < 3'h5 || o_empty);
  endproperty

  a_rst: assert property (p_rst) else $error("state after reset wrong");
  a_hold: assert property (p_hold) else $error("read data moved while deselected");
  a_empty_stop: assert property (p_empty_stop) else $error("read performed while empty");
  a_empty: assert property (p_empty) else $error("empty flag timing wrong");
  a_full: assert property (p_full) else $error("full flag timing wrong");
  a_almost_full_flag: assert property (p_almost_full_flag) else $error("full without almost full");
  a_almost_empty_flag: assert property (p_almost_empty_flag) else $error("empty without almost empty");
  a_rsv: assert property (p_rsv) else $error("reserved code not blocked");
  c_wr_empty: cover property (wa && o_empty);
  c_rd_full: cover property (ra && o_full);
  c_af: cover property (o_almost_full && !o_full);
endmodule

// ### sdcf_user.sv
// Behavioural user logic driving the FIFO write port
`timescale 1ns/100ps
module sdcf_user (
  input  wire logic        i_go,
  input  wire logic [17:0] i_val,
  output logic             o_strobe_n,
  output logic [17:0]      o_data
);
  // Idle bus shows inverted data
  assign o_strobe_n = !i_go;
  assign o_data = i_go ? i_val : ~i_val;
endmodule

// ### sdcf_fifo_tb_top.sv
// Self-checking bench for the FIFO controller
`timescale 1ns/100ps
module sdcf_fifo_tb_top;
  logic        clk = 1'b0, rst = 1'b1, rst_n = 1'b1, wsel_n = 1'b0, rsel_n = 1'b0, empty_stop = 1'b1;
  logic        go = 1'b0, rd = 1'b0, pipe = 1'b0, wstb_n, full, empty, af, ae;
  logic [2:0]  wc = 3'h0, rc = 3'h0;
  logic [17:0] wv = 18'h0, wd, q;
  logic [11:0] aft = 12'h000, aet = 12'h000;
  int          error_cnt = 0, checked = 0;

  sdcf_fifo dut_u (.i_clk(clk), .i_rst(rst), .i_reset_n(rst_n), .i_write_width_code(wc),
    .i_read_width_code(rc), .i_write_port_select_n(wsel_n), .i_read_port_select_n(rsel_n),
    .i_write_strobe(wstb_n), .i_read_strobe(rd), .i_read_pipeline_select(pipe),
    .i_write_data_bus(wd), .i_empty_stop(empty_stop), .i_full_stop(1'b1),
    .i_almost_full_threshold(aft), .i_almost_empty_threshold(aet), .o_read_data(q),
    .o_full(full), .o_empty(empty), .o_almost_full(af), .o_almost_empty(ae));
  sdcf_user usr_u (.i_go(go), .i_val(wv), .o_strobe_n(wstb_n), .o_data(wd));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [17:0] msk(input logic [2:0] c);
    msk = (18'h1 << (c == 3'h4 ? 18 : c == 3'h3 ? 9 : 1 << c)) - 18'h1;
  endfunction
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rst_to(input logic [2:0] w, input logic [2:0] r, input logic p);
    @(posedge clk);
    rst <= 1'b1;
    wc <= w;
    rc <= r;
    pipe <= p;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic wr(input logic [17:0] v);
    @(posedge clk);
    go <= 1'b1;
    wv <= v & msk(wc);
    @(posedge clk);
    go <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [17:0] e);
    @(posedge clk);
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    if (pipe) @(posedge clk);
    #1 chk(q & msk(rc), e & msk(rc));
  endtask

  task automatic t_basic;
    for (int c = 0; c < 5; c++) begin
      for (int p = 0; p < 2; p++) begin
        rst_to(c[2:0], c[2:0], p[0]);
        wr(18'h2d5a3);
        wr(18'h1b3c6);
        repeat (3) @(posedge clk);
        rsel_n <= 1'b1;
        rdc(18'h0);
        @(posedge clk);
        rsel_n <= 1'b0;
        rdc(18'h2d5a3);
        rdc(18'h1b3c6);
        chk(empty, 1'b1);
      end
    end
    $display("basic done");
  endtask
  task automatic t_mix;
    rst_to(3'h1, 3'h2, 1'b0);
    wr(18'h1);
    repeat (4) @(posedge clk);
    #1 chk(empty, 1'b1);
    wr(18'h2);
    repeat (3) @(posedge clk);
    rdc(18'h9);
    chk(empty, 1'b1);
    $display("mixed done");
  endtask
  task automatic t_full;
    rst_to(3'h4, 3'h4, 1'b0);
    aft <= 12'hff0;
    aet <= 12'h020;
    for (int i = 0; i < 256; i++) begin
      wr(18'(i));
      chk(af, 18'(i >= 254));
    end
    chk(full, 1'b1);
    wr(18'h3ffff);
    repeat (3) @(posedge clk);
    for (int i = 0; i < 256; i++) begin
      rdc(18'(i));
      chk(ae, 18'(i >= 253));
    end
    chk(empty, 1'b1);
    rdc(18'hff);
    wr(18'h155);
    repeat (3) @(posedge clk);
    rdc(18'h155);
    $display("full done");
  endtask
  task automatic t_rst;
    wr(18'h1);
    @(posedge clk);
    rst_n <= 1'b0;
    wr(18'h1);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk({full, empty}, 2'b01);
    chk(q, 18'h0);
    @(posedge clk);
    empty_stop <= 1'b0;
    rdc(18'h155);
    @(posedge clk);
    empty_stop <= 1'b1;
    wc <= 3'h5;
    rc <= 3'h7;
    repeat (2) @(posedge clk);
    #1 chk({full, empty}, 2'b11);
    $display("reset done");
  endtask

  task automatic stop_test;
    $display("checks=%0d errors=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_basic;
    t_mix;
    t_full;
    t_rst;
    stop_test;
  end
  initial begin
    #100000;
    error_cnt++;
    stop_test;
  end
endmodule

bind sdcf_fifo sdcf_fifo_chk #(.WRITE_STROBE_ACTIVE_HIGH(WRITE_STROBE_ACTIVE_HIGH),
  .READ_STROBE_ACTIVE_HIGH(READ_STROBE_ACTIVE_HIGH)) chk_u (.i_clk, .i_rst, .i_reset_n,
  .i_write_width_code, .i_read_width_code, .i_write_port_select_n, .i_read_port_select_n,
  .i_write_strobe, .i_read_strobe, .i_read_pipeline_select, .i_empty_stop, .i_full_stop,
  .o_read_data, .o_full, .o_empty, .o_almost_full, .o_almost_empty);
